//--- serial_modem_baud_dma_page.sv
// modem lines, baud selector and dma page-boundary flags of the serial unit
//
// The Wishbone slave port was left to the implementer.
`include "serial_modem_map.svh"

module serial_modem_baud_dma_page
    import serial_modem_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // dma control unit
    input  wire logic        rx_page_i,
    input  wire logic        tx_page_i,
    output logic             rx_dma_hold_o,
    output logic             tx_dma_hold_o,
    // modem line
    input  wire modem_in_t   modem_i,
    output logic             dtr_o,
    output logic             rts_o,
    // rest of the serial unit
    output logic [2:0]       baud_select_o,
    output logic             baud_tick_o,
    output logic             receiver_on_o,
    output logic             transmitter_on_o,
    output logic             infrared_mode_enable_o,
    output logic             infrared_source_o,
    // interrupt
    output logic             irq_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // *********************************************
    // helper functions
    // *********************************************

    // address decode, used by read and write paths
    function automatic reg_sel_t decode(input logic [29:0] idx);
        case (idx)
            `IDX_CTRL:  decode = REG_CTRL;
            `IDX_MASK:  decode = REG_MASK;
            `IDX_FLAGS: decode = REG_FLAGS;
            `IDX_MODEM: decode = REG_MODEM;
            `IDX_BAUD:  decode = REG_BAUD;
            default:    decode = REG_NONE;
        endcase
    endfunction

    // clock cycles per bit for each selector code
    function automatic logic [16:0] baud_div(input logic [2:0] code);
        case (code)
            3'h0:    baud_div = 17'(`CLK_HZ / `BPS_0);
            3'h1:    baud_div = 17'(`CLK_HZ / `BPS_1);
            3'h2:    baud_div = 17'(`CLK_HZ / `BPS_2);
            3'h3:    baud_div = 17'(`CLK_HZ / `BPS_3);
            3'h4:    baud_div = 17'(`CLK_HZ / `BPS_4);
            3'h5:    baud_div = 17'(`CLK_HZ / `BPS_5);
            3'h6:    baud_div = 17'(`CLK_HZ / `BPS_6);
            default: baud_div = 17'(`CLK_HZ / `BPS_7);
        endcase
    endfunction

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wr,
                                          input logic [3:0]  sel);
        merge[7:0]  = sel[0] ? wr[7:0]  : old[7:0];
        merge[15:8] = sel[1] ? wr[15:8] : old[15:8];
    endfunction

    // *********************************************
    // bus front end
    // *********************************************

    bus_req_t    req;        // sampled request
    reg_sel_t    hit;        // decoded target
    logic        take;       // request taken this edge
    logic        wr_en;      // write takes effect
    logic        rd_en;      // read takes effect
    logic [15:0] wr_val;     // write data, low half

    assign req    = '{idx: adr_i[31:2], dat: dat_i, sel: sel_i, we: we_i};
    assign hit    = decode(req.idx);
    assign take   = cyc_i && stb_i && !ack_o;
    assign wr_en  = take && req.we;
    assign rd_en  = take && !req.we;
    assign wr_val = req.dat[15:0];

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= take;
        end
    end

    // *********************************************
    // control, mask and baud registers
    // *********************************************

    logic [15:0] ctrl_q;     // stop, enable and infrared bits
    logic [15:0] mask_q;     // interrupt mask, flag layout
    logic [2:0]  baud_q;     // rate selector

    // control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `RST_CTRL;
        end else if (wr_en && hit == REG_CTRL) begin
            ctrl_q <= merge(ctrl_q, wr_val, req.sel) & `MASK_CTRL;
        end
    end

    // mask register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= `RST_MASK;
        end else if (wr_en && hit == REG_MASK) begin
            mask_q <= merge(mask_q, wr_val, req.sel) & `MASK_FLAGS;
        end
    end

    // rate selector; only three bits kept, the rest read zero
    // a change while the link runs is the software's lookout
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_q <= `RST_BAUD;
        end else if (wr_en && hit == REG_BAUD && req.sel[0]) begin
            baud_q <= wr_val[2:0];
        end
    end

    logic receive_side_enable;               // receive side and modem enabled
    assign receive_side_enable = ctrl_q[`CTL_RSE];

    // configuration outputs to the rest of the unit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_select_o          <= `RST_BAUD;
            receiver_on_o          <= 1'b0;
            transmitter_on_o       <= 1'b0;
            infrared_mode_enable_o <= 1'b0;
            infrared_source_o      <= 1'b0;
        end else begin
            baud_select_o          <= baud_q;
            receiver_on_o          <= ctrl_q[`CTL_RXON];
            transmitter_on_o       <= ctrl_q[`CTL_TXON];
            // only these two bits steer the line to infrared
            infrared_mode_enable_o <= ctrl_q[`CTL_IRMODE];
            infrared_source_o      <= ctrl_q[`CTL_IRSRC];
        end
    end

    // *********************************************
    // baud generator
    // *********************************************

    logic [16:0] baud_cnt_q; // cycles left in this bit
    logic        baud_run;   // generator enabled

    assign baud_run = ctrl_q[`CTL_RXON] | ctrl_q[`CTL_TXON];

    // one-cycle tick per bit time at the selected rate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_cnt_q  <= 17'h00000;
            baud_tick_o <= 1'b0;
        end else if (!baud_run) begin
            // idle: reload so the first bit is full length
            baud_cnt_q  <= baud_div(baud_q) - 17'h00001;
            baud_tick_o <= 1'b0;
        end else if (baud_cnt_q == 17'h00000) begin
            baud_cnt_q  <= baud_div(baud_q) - 17'h00001;
            baud_tick_o <= 1'b1;
        end else begin
            baud_cnt_q  <= baud_cnt_q - 17'h00001;
            baud_tick_o <= 1'b0;
        end
    end

    // *********************************************
    // modem lines
    // *********************************************

    modem_in_t   pin_q;      // first sample of the pins
    modem_in_t   shown_q;    // levels shown in the register
    logic [2:0]  chg_a_q;    // change seen, first delay
    logic [2:0]  chg_b_q;    // change seen, second delay
    logic [1:0]  lines_q;    // dtr, rts as written

    // sample stage; pins are synchronous to the clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_q <= '0;
        end else if (receive_side_enable) begin
            pin_q <= modem_i;
        end
    end

    // shown levels: two clocks after a pin change
    // frozen while the receive side is off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shown_q <= '0;
            chg_a_q <= 3'h0;
        end else if (receive_side_enable) begin
            shown_q <= pin_q;
            chg_a_q <= pin_q ^ shown_q;
        end else begin
            chg_a_q <= 3'h0;
        end
    end

    // two more clocks before the change interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chg_b_q <= 3'h0;
        end else begin
            chg_b_q <= chg_a_q & {3{receive_side_enable}};
        end
    end

    // dtr and rts bits; reset high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lines_q <= {`RST_LINES, `RST_LINES};
        end else if (wr_en && hit == REG_MODEM && req.sel[0]) begin
            lines_q <= {wr_val[`MDM_DTR], wr_val[`MDM_RTS]};
        end
    end

    // pins driven from the written bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dtr_o <= `RST_LINES;
            rts_o <= `RST_LINES;
        end else begin
            dtr_o <= lines_q[1];
            rts_o <= lines_q[0];
        end
    end

    // *********************************************
    // interrupt flags
    // *********************************************

    logic [15:0] flag_q;     // sticky flags
    logic [15:0] flag_d;     // next flags
    logic [15:0] set_v;      // events this cycle
    logic [15:0] clr_v;      // clears this cycle

    // events: page pulses step first then second flag
    always_comb begin
        set_v = 16'h0000;
        if (rx_page_i) begin
            if (flag_q[`FLG_RX1]) begin
                set_v[`FLG_RX2] = 1'b1;
            end else begin
                set_v[`FLG_RX1] = 1'b1;
            end
        end
        if (tx_page_i) begin
            if (flag_q[`FLG_TX1]) begin
                set_v[`FLG_TX2] = 1'b1;
            end else begin
                set_v[`FLG_TX1] = 1'b1;
            end
        end
        set_v[`FLG_CTS] = chg_b_q[0];
        set_v[`FLG_DSR] = chg_b_q[1];
        set_v[`FLG_DCD] = chg_b_q[2];
    end

    // clears: write one per bit, or a read of the register
    always_comb begin
        clr_v = 16'h0000;
        if (wr_en && hit == REG_FLAGS) begin
            clr_v = merge(16'h0000, wr_val, req.sel);
        end else if (rd_en && hit == REG_FLAGS) begin
            clr_v = 16'hFFFF;
        end
        // a set in the clearing cycle survives
        flag_d = ((flag_q & ~clr_v) | set_v) & `MASK_FLAGS;
    end

    // flag storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 16'h0000;
        end else begin
            flag_q <= flag_d;
        end
    end

    // interrupt level follows the unmasked flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flag_d & mask_q);
        end
    end

    // *********************************************
    // dma request hold
    // *********************************************

    // second flag stops requests outright, first flag only
    // with the stop bit; both lift when software clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_dma_hold_o <= 1'b0;
            tx_dma_hold_o <= 1'b0;
        end else begin
            rx_dma_hold_o <= flag_d[`FLG_RX2]
                | (flag_d[`FLG_RX1] & ctrl_q[`CTL_RSP]);
            tx_dma_hold_o <= flag_d[`FLG_TX2]
                | (flag_d[`FLG_TX1] & ctrl_q[`CTL_TSP]);
        end
    end

    // *********************************************
    // read data
    // *********************************************

    logic [15:0] rd_val;     // selected register value

    // reserved positions come back as zero
    always_comb begin
        rd_val = 16'h0000;
        case (hit)
            REG_CTRL:  rd_val = ctrl_q;
            REG_MASK:  rd_val = mask_q;
            REG_FLAGS: rd_val = flag_q;
            REG_MODEM: begin
                rd_val[`MDM_DCD] = shown_q.dcd;
                rd_val[`MDM_DSR] = shown_q.dsr;
                rd_val[`MDM_CTS] = shown_q.cts;
                rd_val[`MDM_DTR] = lines_q[1];
                rd_val[`MDM_RTS] = lines_q[0];
            end
            REG_BAUD:  rd_val = {13'h0000, baud_q};
            default:   rd_val = 16'h0000;
        endcase
    end

    // data registered together with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (rd_en) begin
            dat_o <= {16'h0000, rd_val};
        end else begin
            dat_o <= 32'h00000000;
        end
    end

endmodule // serial_modem_baud_dma_page

//--- serial_modem_map.svh
// register map, field positions, reset values and timing constants
// What this block does
// - rx page with first flag set: second flag, stop
// - rx page: first flag; stop bit withholds requests
// - tx page with first flag set: second flag, stop
// - tx page: first flag; stop bit withholds requests
// - DCD, DSR, CTS shown in bits 4..2
// - pin shown two clocks later, interrupt two after
// - DTR and RTS pins follow bits 1 and 0
// - DTR and RTS reset to one
// - three-bit code picks 1200 to 115200 bps
// - reserved bits read zero, software writes zero
// - infrared chosen only by mode and source bits
// - status flag cleared by writing one
// - receive-side enable gates modem sampling and modem change interrupts
`ifndef SERIAL_MODEM_MAP_SVH
`define SERIAL_MODEM_MAP_SVH

// *********************************************
// register indexes (byte address is four times)
// *********************************************
`define IDX_CTRL   30'h0B000142
`define IDX_MASK   30'h0B000146
`define IDX_FLAGS  30'h0B000148
`define IDX_MODEM  30'h0B00014A
`define IDX_BAUD   30'h0B00014C

// *********************************************
// field positions
// *********************************************
`define FLG_TX1    0
`define FLG_TX2    1
`define FLG_RX1    2
`define FLG_RX2    3
`define FLG_CTS    6
`define FLG_DSR    7
`define FLG_DCD    8
`define MDM_RTS    0
`define MDM_DTR    1
`define MDM_CTS    2
`define MDM_DSR    3
`define MDM_DCD    4
`define CTL_TSP    0
`define CTL_RSP    1
`define CTL_RSE    2
`define CTL_RXON   3
`define CTL_TXON   4
`define CTL_IRMODE 5
`define CTL_IRSRC  6

// *********************************************
// writable masks and reset values
// *********************************************
`define MASK_FLAGS 16'h01CF
`define MASK_CTRL  16'h007F
`define MASK_BAUD  16'h0007
`define RST_CTRL   16'h0000
`define RST_MASK   16'h0000
`define RST_BAUD   3'h0
`define RST_LINES  1'h1

// *********************************************
// clock and bit rates
// *********************************************
`define CLK_HZ     125000000
`define BPS_0      1200
`define BPS_1      2400
`define BPS_2      4800
`define BPS_3      9600
`define BPS_4      19200
`define BPS_5      38400
`define BPS_6      57600
`define BPS_7      115200

`endif

//--- serial_modem_pkg.sv
// types shared by the modem, baud and page-boundary block
package serial_modem_pkg;
    timeunit 1ns;
    timeprecision 1ps;

    // one classic bus request as sampled
    typedef struct packed {
        logic [29:0] idx;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
    } bus_req_t;

    // modem input pins, high level is 1
    typedef struct packed {
        logic dcd;
        logic dsr;
        logic cts;
    } modem_in_t;

    // which register a request hits
    typedef enum logic [5:0] {
        REG_CTRL  = 6'b000001,
        REG_MASK  = 6'b000010,
        REG_FLAGS = 6'b000100,
        REG_MODEM = 6'b001000,
        REG_BAUD  = 6'b010000,
        REG_NONE  = 6'b100000
    } reg_sel_t;

endpackage

//--- serial_modem_checker.sv
// port assertions for the modem, baud and page block
`include "serial_modem_map.svh"
module serial_modem_checker
    import serial_modem_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // dma, lines and rate
    input wire logic        rx_page_i,
    input wire logic        tx_page_i,
    input wire logic        rx_dma_hold_o,
    input wire logic        tx_dma_hold_o,
    input wire logic        dtr_o,
    input wire logic        rts_o,
    input wire logic [2:0]  baud_select_o,
    input wire logic        baud_tick_o,
    input wire logic        receiver_on_o,
    input wire logic        transmitter_on_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // *****
    // helper state
    // *****
    logic       busy;    // any bus request present
    logic       rx1_q;   // rx page seen since last bus access
    logic       tx1_q;   // tx page seen since last bus access
    logic [1:0] lines_q; // last written dtr, rts
    logic [2:0] rate_q;  // last written rate code
    assign busy = cyc_i && stb_i;
    // a bus access may clear flags, so counting restarts there
    always_ff @(posedge clk_i) begin
        if (rst_i || busy) begin
            rx1_q <= 1'b0;
            tx1_q <= 1'b0;
        end else begin
            rx1_q <= rx1_q | rx_page_i;
            tx1_q <= tx1_q | tx_page_i;
        end
    end
    sequence s_take;
        busy && !ack_o;
    endsequence
    sequence s_wr(logic [29:0] idx);
        s_take ##0 (we_i && sel_i[0] && adr_i[31:2] == idx);
    endsequence
    // written values, kept to compare the outputs against
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lines_q <= 2'h3;
            rate_q  <= 3'h0;
        end else begin
            if (busy && !ack_o && we_i && sel_i[0] && adr_i[31:2] == `IDX_MODEM) begin
                lines_q <= dat_i[1:0];
            end
            if (busy && !ack_o && we_i && sel_i[0] && adr_i[31:2] == `IDX_BAUD) begin
                rate_q <= dat_i[2:0];
            end
        end
    end
    // *****
    // assertions
    // *****
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (s_take |=> ack_o)
        else $error("no ack one cycle after request");
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_modem_reserved: assert property (
        ack_o && $past(adr_i) == {`IDX_MODEM, 2'h0} |-> dat_o[15:5] == 11'h000)
        else $error("reserved modem bits not zero");
    a_lines_follow: assert property (
        s_wr(`IDX_MODEM) |=> ##[0:1] ({dtr_o, rts_o} == lines_q))
        else $error("line outputs differ from write");
    a_lines_reset: assert property ($fell(rst_i) |-> dtr_o && rts_o)
        else $error("lines not high after reset");
    a_rate_follow: assert property (
        s_wr(`IDX_BAUD) |=> ##[0:1] (baud_select_o == rate_q))
        else $error("rate output differs from write");
    a_rx_second: assert property (rx_page_i && rx1_q && !busy |=> rx_dma_hold_o)
        else $error("rx not held after second page");
    a_tx_second: assert property (tx_page_i && tx1_q && !busy |=> tx_dma_hold_o)
        else $error("tx not held after second page");
    a_tick_idle: assert property (
        (!receiver_on_o && !transmitter_on_o) [*2] |-> !baud_tick_o)
        else $error("rate tick while stopped");
endmodule // serial_modem_checker

//--- line_dma_partner.sv
// far-side model: dma page pulses and modem input pins
module line_dma_partner
    import serial_modem_pkg::*;
(
    // clock
    input  wire logic clk_i,
    // dma pages and modem pins
    output logic      rx_page_o,
    output logic      tx_page_o,
    output modem_in_t pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet pins and no pages at start
    initial begin
        rx_page_o = 1'b0;
        tx_page_o = 1'b0;
        pins_o    = 3'h0;
    end
    // n back-to-back high cycles, each one page step
    task automatic page(input logic rx, input int n);
        @(posedge clk_i);
        rx_page_o <= rx;
        tx_page_o <= !rx;
        repeat (n) @(posedge clk_i);
        rx_page_o <= 1'b0;
        tx_page_o <= 1'b0;
    endtask
    // pins move just after an edge, like any synchronous source
    task automatic pins(input modem_in_t v);
        @(posedge clk_i);
        pins_o <= v;
    endtask
endmodule // line_dma_partner

//--- tb_serial_modem_baud_dma_page.sv
// self-checking bench for the modem, baud and page block
`include "serial_modem_map.svh"
module tb_serial_modem_baud_dma_page
    import serial_modem_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // *****
    // signals
    // *****
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [31:0] adr_i, dat_i, dat_o;
    logic [3:0]  sel_i;
    logic        rx_page_i, tx_page_i, rx_dma_hold_o, tx_dma_hold_o;
    logic        dtr_o, rts_o, baud_tick_o, receiver_on_o, transmitter_on_o;
    logic        infrared_mode_enable_o, infrared_source_o, irq_o;
    logic [2:0]  baud_select_o;
    modem_in_t   modem_i;
    logic [15:0] exp_q[$]; // expected read data, oldest first
    logic [15:0] r;        // random line values
    int          n_errors, comparisons, seed, k;

    serial_modem_baud_dma_page serial_modem_baud_dma_page_inst (.*);
    line_dma_partner line_dma_partner_inst (.clk_i(clk_i), .rx_page_o(rx_page_i),
        .tx_page_o(tx_page_i), .pins_o(modem_i));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // *****
    // checking and closing
    // *****
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one classic cycle; reads leave their expectation in the queue
    task automatic bus(input logic [29:0] idx, input logic w, input logic [15:0] d,
                       input logic [15:0] e);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'h0};
        sel_i <= 4'h3;
        dat_i <= {16'h0000, d};
        if (!w) exp_q.push_back(e);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            n_errors++;
            conclude();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    // read data is taken at the ack edge, request still held
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            if (exp_q.size() == 0) n_errors++;
            else check(dat_o[15:0], exp_q.pop_front());
        end
    end
    // a hang ends the run as a failure
    initial begin
        repeat (100000) @(posedge clk_i);
        n_errors++;
        conclude();
    end
    // *****
    // main sequence
    // *****
    initial begin
        seed = 76;
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 71'h0};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({dtr_o, rts_o}, 16'h0003);
        bus(`IDX_MODEM, 1'b0, 16'h0000, 16'h0003);
        for (int i = 0; i < 8; i++) begin
            bus(`IDX_BAUD, 1'b1, 16'(i), 16'h0000);
            bus(`IDX_BAUD, 1'b0, 16'h0000, 16'(i));
            check(16'(baud_select_o), 16'(i));
        end
        repeat (4) begin
            r = 16'($random(seed));
            bus(30'h0B000150, 1'b1, r, 16'h0000); // unmapped, ignored
            bus(30'h0B000150, 1'b0, 16'h0000, 16'h0000);
            bus(`IDX_MODEM, 1'b1, r & 16'h0003, 16'h0000);
            bus(`IDX_MODEM, 1'b0, 16'h0000, r & 16'h0003);
            check({dtr_o, rts_o}, r & 16'h0003);
        end
        // rate is set before the link runs, never while it runs
        bus(`IDX_CTRL, 1'b1, 16'h0078, 16'h0000);
        bus(`IDX_CTRL, 1'b0, 16'h0000, 16'h0078);
        check({receiver_on_o, transmitter_on_o, infrared_mode_enable_o,
               infrared_source_o}, 16'h000F);
        k = 0;
        while (baud_tick_o !== 1'b1 && k < 3000) begin
            @(posedge clk_i);
            k++;
        end
        // a generator that never ticks ends the run at once
        if (k == 3000) begin
            n_errors++;
            conclude();
        end
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (baud_tick_o !== 1'b1 && k < 3000);
        check(16'(k), 16'h043D);
        bus(`IDX_MASK, 1'b1, 16'h01CF, 16'h0000);
        bus(`IDX_CTRL, 1'b1, 16'h0000, 16'h0000);
        line_dma_partner_inst.pins(3'h7);
        repeat (6) @(posedge clk_i);
        bus(`IDX_FLAGS, 1'b0, 16'h0000, 16'h0000);
        bus(`IDX_MODEM, 1'b0, 16'h0000, r & 16'h0003);
        line_dma_partner_inst.pins(3'h0);
        bus(`IDX_CTRL, 1'b1, 16'h0004, 16'h0000);
        repeat (6) @(posedge clk_i);
        bus(`IDX_FLAGS, 1'b1, 16'h01CF, 16'h0000);
        line_dma_partner_inst.pins(3'h4);
        for (int i = 1; i <= 5; i++) begin
            @(posedge clk_i);
            check(16'(irq_o), 16'(i == 5));
        end
        bus(`IDX_MODEM, 1'b0, 16'h0000, 16'h0010 | (r & 16'h0003));
        bus(`IDX_FLAGS, 1'b0, 16'h0000, 16'h0100);
        line_dma_partner_inst.pins(3'h7);
        repeat (8) @(posedge clk_i);
        bus(`IDX_FLAGS, 1'b1, 16'h0080, 16'h0000);
        bus(`IDX_FLAGS, 1'b0, 16'h0000, 16'h0040);
        bus(`IDX_CTRL, 1'b1, 16'h0002, 16'h0000);
        check(16'(irq_o), 16'h0000);
        line_dma_partner_inst.page(1'b1, 1);
        @(posedge clk_i);
        check({rx_dma_hold_o, tx_dma_hold_o, irq_o}, 16'h0005);
        line_dma_partner_inst.page(1'b0, 1);
        @(posedge clk_i);
        check({rx_dma_hold_o, tx_dma_hold_o, irq_o}, 16'h0005);
        line_dma_partner_inst.page(1'b0, 1);
        @(posedge clk_i);
        check({rx_dma_hold_o, tx_dma_hold_o, irq_o}, 16'h0007);
        bus(`IDX_FLAGS, 1'b0, 16'h0000, 16'h0007);
        bus(`IDX_CTRL, 1'b1, 16'h0001, 16'h0000);
        check({rx_dma_hold_o, tx_dma_hold_o}, 16'h0000);
        line_dma_partner_inst.page(1'b1, 2);
        @(posedge clk_i);
        check({rx_dma_hold_o, tx_dma_hold_o}, 16'h0002);
        line_dma_partner_inst.page(1'b0, 1);
        @(posedge clk_i);
        check({rx_dma_hold_o, tx_dma_hold_o}, 16'h0003);
        bus(`IDX_MASK, 1'b1, 16'h0000, 16'h0000);
        bus(`IDX_FLAGS, 1'b0, 16'h0000, 16'h000D);
        line_dma_partner_inst.page(1'b1, 1);
        @(posedge clk_i);
        check(16'(irq_o), 16'h0000);
        bus(`IDX_FLAGS, 1'b0, 16'h0000, 16'h0004);
        @(posedge clk_i);
        conclude();
    end
endmodule // tb_serial_modem_baud_dma_page

bind serial_modem_baud_dma_page serial_modem_checker serial_modem_checker_inst (.*);
